// [core/swm_pkg.sv]
// constants, field layout and wire-mode type of the serial wire mode block
package swm_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_DATA = 3'h1;
    localparam logic [2:0] ADDR_CNT  = 3'h2;
    localparam logic [2:0] ADDR_PORT = 3'h3;
    localparam logic [2:0] ADDR_DIR  = 3'h4;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int CTRL_IE_HI = 7;
    localparam int CTRL_IE_LO = 6;
    localparam int CTRL_WM_HI = 5;
    localparam int CTRL_WM_LO = 4;
    localparam int CTRL_CS_HI = 3;
    localparam int CTRL_CS_LO = 2;
    localparam int CTRL_CLK   = 1;
    localparam int CTRL_TGL   = 0;

    // ----------------------------------------------------------------
    // port and direction register bits
    // ----------------------------------------------------------------
    localparam int PIN_DO = 0;
    localparam int PIN_DI = 1;
    localparam int PIN_CK = 2;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [3:0] CNT_RST  = 4'h0;
    localparam logic [2:0] PORT_RST = 3'h0;
    localparam logic [2:0] DIR_RST  = 3'h0;

    // ----------------------------------------------------------------
    // wire modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SWM_OFF      = 2'b00,
        SWM_THREE    = 2'b01,
        SWM_TWO      = 2'b10,
        SWM_TWO_HOLD = 2'b11
    } swm_wire_e;

    // two-wire decode from the mode msb; not called by the pin or hold logic
    function automatic logic swm_two_wire(input logic [1:0] wm);
        return wm[1];
    endfunction

endpackage

// [core/swm_ctrl.sv]
// wire mode, clock source select, data register, counter and pin drive
`timescale 1ns/10ps

// What this block does
// (RULE1) Wire mode zero: outputs, hold, start detector off; pins are port pins.
// (RULE2) Three-wire: serial data replaces port output bit; direction stays.
// (RULE3) Three-wire data pin as input: pull-up follows port output bit.
// (RULE4) Three-wire: data-in and clock pins keep plain port behaviour.
// (RULE5) Three-wire master software makes clock by toggling clock pin.
// (RULE6) Two-wire: both lines open collector, driver on only if direction set.
// (RULE7) Two-wire: data line pulled low if register bit or port bit zero.
// (RULE8) Two-wire: clock line pulled low if port bit zero or hold active.
// (RULE9) Two-wire: start hold keeps clock low until start flag cleared.
// (RULE10) Two-wire: plain port function of both lines disabled.
// (RULE11) Mode three also holds clock low from overflow until flag cleared.
// (RULE12) Inputs always work; register and counter clock in any mode.
// (RULE13) External clock: output changes on edge opposite to sampling.
// (RULE14) Strobe or timer clock: output latch transparent.
// (RULE15) Source zero: no clock or strobe; source one: timer match.
// (RULE16) External: shift on chosen edge; counter both edges or toggle.
// (RULE17) Clock strobe write shifts register once and steps counter.
// (RULE18) Strobe output same cycle; shifted bit is previous cycle's input.
// (RULE19) Clock strobe bit reads zero.
// (RULE20) Toggle strobe inverts clock pin port value; reads zero.
// (RULE21) Data output pin driven from register msb via output latch.
// (RULE22) Strobe under external or timer option does nothing.
module swm_ctrl #(
    parameter int CNT_W = 4
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // register port
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    // neighbouring logic
    input  wire logic       timer_match,
    input  wire logic       start_flag,
    input  wire logic       overflow_flag,
    output logic            start_detect_en,
    output logic            sda_level,
    output logic            scl_level,
    output logic            count_step,
    output logic            count_overflow,
    // data output pin
    output logic            do_o,
    output logic            do_oe,
    output logic            do_pullup,
    // data input / two-wire data pin
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    output logic            sda_pullup,
    // clock pin
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    output logic            scl_pullup
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0]       ctrl_q;
    logic [7:0]       dr_q;
    logic [7:0]       dr_d;
    logic [CNT_W-1:0] cnt_q;
    logic [2:0]       port_q;
    logic [2:0]       dir_q;
    logic             latch_q;
    logic [1:0]       sda_sync_q;
    logic [1:0]       scl_sync_q;
    logic             scl_prev_q;
    logic             di_prev_q;
    logic [2:0]       edge_arm_q;
    logic             scl_hold;

    logic [1:0]       wm;
    logic [1:0]       cs;
    logic             ext_clk;
    logic             wr_ctrl;
    logic             sw_strobe;
    logic             tgl_strobe;
    logic             scl_rise;
    logic             scl_fall;
    logic             shift_edge;
    logic             latch_edge;
    logic             do_shift;
    logic             do_count;
    logic             shift_in;

    // counter must fit the byte-wide register port
    if (CNT_W < 1 || CNT_W > 8) begin : g_bad_cnt_w
        $error("swm_ctrl: CNT_W must be 1..8");
    end

    assign wm      = ctrl_q[swm_pkg::CTRL_WM_HI:swm_pkg::CTRL_WM_LO];
    assign cs      = ctrl_q[swm_pkg::CTRL_CS_HI:swm_pkg::CTRL_CS_LO];
    assign ext_clk = cs[1];
    assign wr_ctrl = wr_en && (addr == swm_pkg::ADDR_CTRL);

    // ----------------------------------------------------------------
    // pin input synchronisers
    // ----------------------------------------------------------------
    // (RULE12) inputs sampled whatever the mode
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sda_sync_q <= 2'h3;
            scl_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            di_prev_q  <= 1'b1;
            edge_arm_q <= 3'h0;
        end else begin
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_sync_q <= {scl_sync_q[0], scl_i};
            scl_prev_q <= scl_sync_q[1];
            di_prev_q  <= sda_sync_q[1];
            edge_arm_q <= {edge_arm_q[1:0], 1'b1};
        end
    end

    assign sda_level = sda_sync_q[1];
    assign scl_level = scl_sync_q[1];
    // no false edge while the chain refills after reset
    assign scl_rise  = edge_arm_q[2] && scl_sync_q[1] && !scl_prev_q;
    assign scl_fall  = edge_arm_q[2] && !scl_sync_q[1] && scl_prev_q;

    // ----------------------------------------------------------------
    // clock source select
    // ----------------------------------------------------------------
    // (RULE17) strobe only with source field zero in the written value
    // (RULE22) no strobe effect under timer source
    assign sw_strobe = wr_ctrl && wr_data[swm_pkg::CTRL_CLK]
                       && (wr_data[swm_pkg::CTRL_CS_HI:swm_pkg::CTRL_CS_LO]
                           == 2'b00);
    assign tgl_strobe = wr_ctrl && wr_data[swm_pkg::CTRL_TGL];

    // (RULE16) shift edge chosen by low select bit
    assign shift_edge = cs[0] ? scl_fall : scl_rise;
    // (RULE13) latch moves on the edge opposite to sampling
    assign latch_edge = cs[0] ? scl_rise : scl_fall;

    // (RULE15) source decode; a strobe obeys the newly written field
    always_comb begin
        do_shift = 1'b0;
        do_count = 1'b0;
        shift_in = sda_sync_q[1];
        if (sw_strobe) begin
            // (RULE18) strobe shifts in previous cycle's input
            do_shift = 1'b1;
            do_count = 1'b1;
            shift_in = di_prev_q;
        end else if (ext_clk) begin
            do_shift = shift_edge;
            // (RULE16) counter on both edges or on toggle writes
            if (ctrl_q[swm_pkg::CTRL_CLK]) begin
                do_count = tgl_strobe;
            end else begin
                do_count = scl_rise || scl_fall;
            end
        end else if (cs[0]) begin
            do_shift = timer_match;
            do_count = timer_match;
        end
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    // (RULE19) clock strobe bit kept as counter clock select only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_q <= swm_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= {wr_data[7:2],
                       wr_data[swm_pkg::CTRL_CLK]
                       && wr_data[swm_pkg::CTRL_CS_HI],
                       1'b0};
        end
    end

    // ----------------------------------------------------------------
    // data register and output latch
    // ----------------------------------------------------------------
    // (RULE17) one left shift per clock, software write wins
    always_comb begin
        dr_d = dr_q;
        if (wr_en && (addr == swm_pkg::ADDR_DATA)) begin
            dr_d = wr_data;
        end else if (do_shift) begin
            dr_d = {dr_q[6:0], shift_in};
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dr_q <= swm_pkg::DATA_RST;
        end else begin
            dr_q <= dr_d;
        end
    end

    // (RULE21) output latch fed from the register msb
    // (RULE14) internal sources: latch follows next msb at once
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            latch_q <= 1'b0;
        end else if (!ext_clk) begin
            latch_q <= dr_d[7];
        end else if (latch_edge) begin
            latch_q <= dr_q[7];
        end
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q <= CNT_W'(swm_pkg::CNT_RST);
        end else if (wr_en && (addr == swm_pkg::ADDR_CNT)) begin
            cnt_q <= wr_data[CNT_W-1:0];
        end else if (do_count) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count_step     <= 1'b0;
            count_overflow <= 1'b0;
        end else begin
            count_step     <= do_count;
            count_overflow <= do_count && (&cnt_q)
                              && !(wr_en && (addr == swm_pkg::ADDR_CNT));
        end
    end

    // ----------------------------------------------------------------
    // port output and direction bits
    // ----------------------------------------------------------------
    // (RULE20) toggle write inverts clock pin value, any direction
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            port_q <= swm_pkg::PORT_RST;
        end else if (wr_en && (addr == swm_pkg::ADDR_PORT)) begin
            port_q <= wr_data[2:0];
        end else if (tgl_strobe) begin
            port_q[swm_pkg::PIN_CK] <= !port_q[swm_pkg::PIN_CK];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dir_q <= swm_pkg::DIR_RST;
        end else if (wr_en && (addr == swm_pkg::ADDR_DIR)) begin
            dir_q <= wr_data[2:0];
        end
    end

    // ----------------------------------------------------------------
    // pin drive per wire mode
    // ----------------------------------------------------------------
    // (RULE9) start hold, (RULE11) overflow hold in hold mode
    assign scl_hold = start_flag
                      || ((wm == swm_pkg::SWM_TWO_HOLD) && overflow_flag);
    // (RULE1) start detector off with outputs disabled
    assign start_detect_en = (wm != swm_pkg::SWM_OFF);

    always_comb begin
        do_o       = port_q[swm_pkg::PIN_DO];
        do_oe      = dir_q[swm_pkg::PIN_DO];
        // (RULE3) input pull-up follows port bit
        do_pullup  = !dir_q[swm_pkg::PIN_DO] && port_q[swm_pkg::PIN_DO];
        sda_o      = port_q[swm_pkg::PIN_DI];
        sda_oe     = dir_q[swm_pkg::PIN_DI];
        sda_pullup = !dir_q[swm_pkg::PIN_DI] && port_q[swm_pkg::PIN_DI];
        scl_o      = port_q[swm_pkg::PIN_CK];
        scl_oe     = dir_q[swm_pkg::PIN_CK];
        scl_pullup = !dir_q[swm_pkg::PIN_CK] && port_q[swm_pkg::PIN_CK];
        unique case (swm_pkg::swm_wire_e'(wm))
            // (RULE1) plain port pins
            swm_pkg::SWM_OFF: begin
            end
            // (RULE2) serial data replaces port bit
            // (RULE4) data-in and clock pins untouched
            swm_pkg::SWM_THREE: begin
                do_o = latch_q;
            end
            // (RULE6) open collector, enabled by direction bit
            // (RULE10) port function of both lines off
            swm_pkg::SWM_TWO, swm_pkg::SWM_TWO_HOLD: begin
                sda_o      = 1'b0;
                scl_o      = 1'b0;
                sda_pullup = 1'b0;
                scl_pullup = 1'b0;
                // (RULE7) pull data low on either zero
                sda_oe = dir_q[swm_pkg::PIN_DI]
                         && (!latch_q || !port_q[swm_pkg::PIN_DI]);
                // (RULE8) pull clock low on port zero or hold
                scl_oe = dir_q[swm_pkg::PIN_CK]
                         && (!port_q[swm_pkg::PIN_CK] || scl_hold);
            end
        endcase
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // (RULE19) (RULE20) strobe bits read zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            unique case (addr)
                swm_pkg::ADDR_CTRL: rd_data <= {ctrl_q[7:2], 2'b00};
                swm_pkg::ADDR_DATA: rd_data <= dr_q;
                swm_pkg::ADDR_CNT:  rd_data <= 8'(cnt_q);
                swm_pkg::ADDR_PORT: rd_data <= {5'h00, port_q};
                swm_pkg::ADDR_DIR:  rd_data <= {5'h00, dir_q};
                default:            rd_data <= 8'h00;
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end

endmodule

// [dv/swm_ctrl_asserts.sv]
// port assertions of the serial wire mode block
`timescale 1ns/10ps
module swm_ctrl_asserts (
    // clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rd_data,
    // neighbours and pins
    input wire logic       start_flag,
    input wire logic       overflow_flag,
    input wire logic       start_detect_en,
    input wire logic       count_step,
    input wire logic       count_overflow,
    input wire logic       do_oe,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic       sda_pullup,
    input wire logic       scl_o,
    input wire logic       scl_oe,
    input wire logic       scl_pullup
);
    logic [1:0] wm_q;
    logic [2:0] dir_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ----------------------------------------------------------------
    // shadows of wire mode and direction
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wm_q <= 2'b00;
        end else if (wr_en && addr == swm_pkg::ADDR_CTRL) begin
            wm_q <= wr_data[5:4];
        end
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dir_q <= 3'h0;
        end else if (wr_en && addr == swm_pkg::ADDR_DIR) begin
            dir_q <= wr_data[2:0];
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    rd_idle_zero_a : assert property (
        !$past(rd_en) |-> rd_data == 8'h00) else $error("rd_data not zero");
    strobe_reads_zero_a : assert property (
        rd_en && addr == swm_pkg::ADDR_CTRL |=> rd_data[1:0] == 2'b00)
        else $error("strobe bits read back set");
    start_det_mode_a : assert property (
        start_detect_en == (wm_q != 2'b00)) else $error("start detect en");
    two_wire_drive_a : assert property (
        wm_q[1] |-> !sda_o && !scl_o && !sda_pullup && !scl_pullup)
        else $error("two-wire lines not open collector");
    two_wire_off_a : assert property (
        wm_q[1] && !dir_q[1] |-> !sda_oe) else $error("sda driver on");
    start_hold_a : assert property (
        wm_q[1] && dir_q[2] && start_flag |-> scl_oe)
        else $error("start hold missing");
    ovf_hold_a : assert property (
        wm_q == 2'b11 && dir_q[2] && overflow_flag |-> scl_oe)
        else $error("overflow hold missing");
    do_dir_a : assert property (
        do_oe == dir_q[0]) else $error("data out enable");
    plain_pins_a : assert property (
        !wm_q[1] |-> sda_oe == dir_q[1] && scl_oe == dir_q[2])
        else $error("plain pin enable");
    sw_strobe_step_a : assert property (
        wr_en && addr == swm_pkg::ADDR_CTRL && wr_data[3:1] == 3'b001
        |=> count_step) else $error("strobe did not step");
    ovf_with_step_a : assert property (
        count_overflow |-> count_step) else $error("overflow without step");
endmodule

// [dv/swm_peer.sv]
// serial peer clocking data onto the data and clock pins in frames
`timescale 1ns/10ps
module swm_peer (
    // pin side
    output logic      sck,
    output logic      sd,
    output logic      sd_en,
    input  wire logic miso
);
    initial begin
        sck = 1'b0;
        sd = 1'b0;
        sd_en = 1'b0;
    end

    // clock runs in frames only, data moves mid-low
    task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
        sd_en = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            #20 sd = tx[i];
            #20 sck = 1'b1;
            #38 rx[i] = miso;
            #2 sck = 1'b0;
        end
        #20 sd_en = 1'b0;
        sd = ~sd;
    endtask
endmodule

// [dv/swm_ctrl_tb_top.sv]
// self-checking testbench of the serial wire mode block
`timescale 1ns/10ps
module swm_ctrl_tb_top;
    logic       clk, reset_n, wr_en, rd_en, timer_match, tb_sda;
    logic       start_flag, overflow_flag, p_sck, p_sd, p_en;
    logic [2:0] addr, pr, dr;
    logic [7:0] wr_data, rd_data, v, d, w, rx;
    logic [3:0] c;
    logic [1:0] wm;
    logic [6:0] pe;
    logic [31:0] rs;
    logic       start_detect_en, sda_level, scl_level, count_step;
    logic       count_overflow, do_o, do_oe, do_pullup, sda_i, sda_o;
    logic       sda_oe, sda_pullup, scl_i, scl_o, scl_oe, scl_pullup;
    int         mismatches, n_compared, n_ovf, e_ovf;
    logic [7:0] tcv [3] = '{8'h10, 8'h14, 8'h16};
    logic [7:0] tst [3] = '{8'h00, 8'h01, 8'h01};

    assign sda_i = sda_oe ? sda_o : (p_en ? p_sd : tb_sda);
    assign scl_i = scl_oe ? scl_o : p_sck;

    swm_ctrl #(.CNT_W(4)) i_dut (.clk, .reset_n, .addr, .wr_data, .wr_en,
        .rd_en, .rd_data, .timer_match, .start_flag, .overflow_flag,
        .start_detect_en, .sda_level, .scl_level, .count_step,
        .count_overflow, .do_o, .do_oe, .do_pullup, .sda_i, .sda_o, .sda_oe,
        .sda_pullup, .scl_i, .scl_o, .scl_oe, .scl_pullup);
    swm_peer i_peer (.sck(p_sck), .sd(p_sd), .sd_en(p_en), .miso(do_o));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] nxt();
        repeat (8) rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
        return rs[7:0];
    endfunction
    function automatic logic [6:0] pins(input logic [1:0] m,
        input logic [2:0] p, q, input logic b, sf, of);
        logic h;
        h = sf | (m == 2'b11 && of);
        if (m[1]) begin
            return {p[0], q[0], ~q[0] & p[0], q[1] & (~b | ~p[1]), 1'b0,
                    q[2] & (~p[2] | h), 1'b0};
        end
        return {m == 2'b01 ? b : p[0], q[0], ~q[0] & p[0], q[1],
                ~q[1] & p[1], q[2], ~q[2] & p[2]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] x);
        addr <= a;
        wr_data <= x;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] e, string nm);
        logic [7:0] g;
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 g = rd_data;
        @(posedge clk);
        chk(nm, e, g);
    endtask
    task automatic ext(input logic [7:0] ctl);
        wr(swm_pkg::ADDR_CTRL, ctl);
        v = nxt();
        #3 i_peer.frame(v, rx);
        repeat (5) @(posedge clk);
        rc(swm_pkg::ADDR_DATA, v, "ext data");
        rc(swm_pkg::ADDR_CNT, 8'h00, "ext cnt");
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (count_overflow === 1'b1) n_ovf++;
    end
    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {reset_n, wr_en, rd_en, timer_match, start_flag} = 5'h0;
        {overflow_flag, tb_sda, addr, wr_data} = 13'h0;
        rs = 32'hcc76;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        wr(3'h7, 8'hff);
        for (int a = 0; a < 8; a++) rc(3'(a), 8'h00, "reset");
        wr(swm_pkg::ADDR_DIR, 8'h01);
        wr(swm_pkg::ADDR_CTRL, 8'h10);
        d = nxt();
        wr(swm_pkg::ADDR_DATA, d);
        ext(8'h18);
        e_ovf++;
        chk("ext rx", d, rx);
        ext(8'h0e);
        // software clock by toggling the clock pin
        wr(swm_pkg::ADDR_CTRL, 8'h0f);
        rc(swm_pkg::ADDR_CNT, 8'h01, "toggle step");
        rc(swm_pkg::ADDR_PORT, 8'h04, "toggle");
        rc(swm_pkg::ADDR_CTRL, 8'h0c, "ctrl rd");
        $display("test external clock done");
        wr(swm_pkg::ADDR_CTRL, 8'h10);
        for (int r = 0; r < 4; r++) begin
            d = nxt();
            c = r == 0 ? 4'hf : 4'(nxt());
            wr(swm_pkg::ADDR_CNT, {4'h0, c});
            wr(swm_pkg::ADDR_DATA, d);
            for (int k = 0; k < 8; k++) begin
                v = nxt();
                tb_sda <= v[0];
                repeat (3) @(posedge clk);
                wr(swm_pkg::ADDR_CTRL, 8'h12);
                d = {d[6:0], v[0]};
                if (c == 4'hf) e_ovf++;
                c = c + 4'h1;
                chk("do_o", {7'h0, d[7]}, {7'h0, do_o});
            end
            rc(swm_pkg::ADDR_DATA, d, "shift data");
            rc(swm_pkg::ADDR_CNT, {4'h0, c}, "shift cnt");
        end
        for (int i = 0; i < 3; i++) begin
            c = c + tst[i][3:0];
            if (c == 4'h0 && tst[i][0]) e_ovf++;
            wr(swm_pkg::ADDR_CTRL, tcv[i]);
            timer_match <= 1'b1;
            @(posedge clk);
            timer_match <= 1'b0;
            @(posedge clk);
            rc(swm_pkg::ADDR_CNT, {4'h0, c}, "timer");
        end
        chk("overflows", 8'(e_ovf), 8'(n_ovf));
        $display("test strobe and timer done");
        for (int i = 0; i < 24; i++) begin
            v = nxt();
            w = nxt();
            wm = i < 4 ? 2'(i) : v[1:0];
            pr = v[4:2];
            dr = v[7:5];
            wr(swm_pkg::ADDR_CTRL, {2'b00, wm, 4'h0});
            wr(swm_pkg::ADDR_PORT, {5'h0, pr});
            wr(swm_pkg::ADDR_DIR, {5'h0, dr});
            wr(swm_pkg::ADDR_DATA, w);
            start_flag <= w[1];
            overflow_flag <= w[2];
            @(posedge clk);
            pe = pins(wm, pr, dr, w[7], w[1], w[2]);
            #1 chk("pins", {1'b0, pe},
                {1'b0, do_o, do_oe, do_pullup, sda_oe, sda_pullup, scl_oe,
                scl_pullup});
            chk("pins mode", {4'h0, wm, 2'b00}, {4'h0, wm,
                start_detect_en !== (wm != 2'b00), 1'b0});
            repeat (2) @(posedge clk);
            chk("levels", {6'h0, (pe[3] ? !wm[1] && pr[1] : tb_sda),
                pe[1] && !wm[1] && pr[2]}, {6'h0, sda_level,
                scl_level});
        end
        $display("test pin modes done");
        wrap_up();
    end
endmodule

bind swm_ctrl swm_ctrl_asserts i_chk (.clk, .reset_n, .addr, .wr_data,
    .wr_en, .rd_en, .rd_data, .start_flag, .overflow_flag, .start_detect_en,
    .count_step, .count_overflow, .do_oe, .sda_o, .sda_oe, .sda_pullup,
    .scl_o, .scl_oe, .scl_pullup);
